//--- design/adc_host_pkg.sv
package adc_host_pkg;

    // clock and pin timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int WAKE_TIME_NS   = 360;
    localparam int ACQ_TIME_NS    = 160;
    localparam int WR_PULSE_NS    = 250;
    localparam int WR_TO_RD_NS    = 250;
    localparam int CONV_TOTAL_NS  = 660;
    localparam int READ_ACCESS_NS = CONV_TOTAL_NS - WR_PULSE_NS - WR_TO_RD_NS;

    // least time, rounded up to whole cycles, never below one
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CNT_W        = 8;
    localparam int WAKE_CYC     = min_cycles(WAKE_TIME_NS);
    localparam int ACQ_CYC      = min_cycles(ACQ_TIME_NS);
    localparam int WR_CYC       = min_cycles(WR_PULSE_NS);
    localparam int GAP_CYC      = min_cycles(WR_TO_RD_NS);
    localparam int ACCESS_CYC   = min_cycles(READ_ACCESS_NS);
    // synchroniser depth of the pin inputs
    localparam int SYNC_CYC     = 2;

    // register map, word index = byte address / 4
    localparam int         ADDR_W     = 4;
    localparam logic [1:0] IDX_CTRL   = 2'h0;
    localparam logic [1:0] IDX_STATUS = 2'h1;
    localparam logic [1:0] IDX_DATA   = 2'h2;

    // control word fields
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_CHAN_LSB   = 1;
    localparam int CTRL_MODE_BIT   = 4;
    localparam int CTRL_WAKE_BIT   = 5;
    localparam int CTRL_METHOD_LSB = 6;

    // status word fields
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_DONE_BIT  = 1;
    localparam int STAT_READY_BIT = 2;
    localparam int STAT_INIT_BIT  = 3;

    // data word fields
    localparam int DATA_CHAN_LSB = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        METHOD_WAIT_INT = 2'h0,
        METHOD_EARLY    = 2'h1,
        METHOD_PIPE     = 2'h2
    } method_type;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SETUP  = 3'h1,
        ST_STROBE = 3'h3,
        ST_GAP    = 3'h2,
        ST_READ   = 3'h6,
        ST_FINISH = 3'h7
    } state_type;

endpackage

//--- design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_type;

    sync_type r;
    sync_type n;

    always_comb begin
        n        = r;
        n.first  = d;
        n.second = r.first;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q = r.second;

endmodule

`default_nettype wire

//--- design/adc_host.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - device forms result as upper four bits then lower four bits
// R2 - three channel select bits pick input one to eight in binary
// R3 - eighth channel converts the upper reference voltage
// R4 - sleep low shuts converter down, high wakes it to tracking
// R5 - host waits 360ns after waking before a new conversion
// R6 - mode select low gives read mode, high gives write-read mode
// R7 - host keeps channel address stable for acquisition time before conversion
// R8 - read mode: host starts conversion with chip select and read low
// R9 - read mode: host may hold read low until result appears
// R10 - read mode: write/ready pin is open-collector ready, low while converting
// R11 - read mode: done flag low at end, cleared by select or read rise
// R12 - write-read mode: conversion starts at write falling edge
// R13 - write rise latches upper bits, lower pass then sets done
// R14 - after done, select and read low put result on data bus
// R15 - host allows acquisition time from done to next write fall; pipelined path times it from strobe release and never waits for done
// R16 - early read low finishes conversion at once and enables outputs
// R17 - early read gives 660ns total from write through result access
// R18 - pipelined: write and read tied, start new and output previous result
// R19 - device ignores write and read unless chip select low
// R20 - mode select defaults to read mode when unconnected
// R21 - host discards one conversion after power-up to initialise device
// R22 - data outputs float whenever chip select or read is high
module adc_host
    import adc_host_pkg::*;
#(
    parameter logic [CNT_W-1:0] WAKE_CYCLES   = CNT_W'(WAKE_CYC),
    parameter logic [CNT_W-1:0] ACQ_CYCLES    = CNT_W'(ACQ_CYC),
    parameter logic [CNT_W-1:0] WR_CYCLES     = CNT_W'(WR_CYC),
    parameter logic [CNT_W-1:0] GAP_CYCLES    = CNT_W'(GAP_CYC),
    parameter logic [CNT_W-1:0] ACCESS_CYCLES = CNT_W'(ACCESS_CYC)
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic                   cs_n,
    output logic                   rd_n,
    output logic                   wr_rdy_out,
    output logic                   wr_rdy_oe,
    input  wire logic              wr_rdy_in,
    input  wire logic              conv_done_n,
    input  wire logic [7:0]        result_bus,
    output logic                   mode_sel,
    output logic                   sleep_n,
    output logic                   channel_sel_bit0,
    output logic                   channel_sel_bit1,
    output logic                   channel_sel_bit2
);

    typedef struct packed {
        state_type        state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] wake_cnt;
        logic [CNT_W-1:0] stable_cnt;
        logic             cs_n;
        logic             rd_n;
        logic             wr_n;
        logic             sleep_n;
        logic             mode;
        logic [2:0]       chan;
        method_type       method;
        logic             start_pend;
        logic             done;
        logic             init_done;
        logic [7:0]       result;
        logic [2:0]       res_chan;
        logic             aw_have;
        logic [1:0]       aw_idx;
        logic             w_have;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } ctl_type;

    ctl_type    r;
    ctl_type    n;
    logic       capture;
    logic       rdy_s;
    logic       int_n_s;
    logic [7:0] res_s;

    function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] a);
        return a[3:2];
    endfunction

    function automatic logic idx_mapped(input logic [1:0] idx);
        return (idx == IDX_CTRL) || (idx == IDX_STATUS) || (idx == IDX_DATA);
    endfunction

    pin_sync #(
        .WIDTH (10)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({wr_rdy_in, conv_done_n, result_bus}),
        .q       ({rdy_s, int_n_s, res_s})
    );

    always_comb begin
        n       = r;
        capture = 1'b0;

        if (r.wake_cnt != '0) begin
            n.wake_cnt = r.wake_cnt - CNT_W'(1);
        end

        // write channels taken in either order
        if (awvalid && r.awready) begin
            n.aw_have = 1'b1;
            n.aw_idx  = reg_index(awaddr);
        end
        if (wvalid && r.wready) begin
            n.w_have = 1'b1;
            n.wdata  = wdata;
            n.wstrb  = wstrb;
        end
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_have && r.w_have && !r.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = idx_mapped(r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
            if (r.aw_idx == IDX_CTRL && r.wstrb[0]) begin
                if (r.wdata[CTRL_START_BIT]) begin
                    n.start_pend = 1'b1;
                end
                // pins change only between conversions
                if (r.state == ST_IDLE) begin
                    n.chan    = r.wdata[CTRL_CHAN_LSB +: 3]; // R2 R3
                    n.mode    = r.wdata[CTRL_MODE_BIT]; // R6 R20
                    n.method  = method_type'(r.wdata[CTRL_METHOD_LSB +: 2]);
                    n.sleep_n = r.wdata[CTRL_WAKE_BIT]; // R4
                    if (!r.sleep_n && r.wdata[CTRL_WAKE_BIT]) begin
                        n.wake_cnt = WAKE_CYCLES; // R5
                    end
                end
            end
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready  = !n.w_have && !n.bvalid;

        // read channel
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            n.rdata  = 32'h0000_0000;
            case (reg_index(araddr))
                IDX_CTRL: begin
                    n.rdata[CTRL_CHAN_LSB +: 3]   = r.chan;
                    n.rdata[CTRL_MODE_BIT]        = r.mode;
                    n.rdata[CTRL_WAKE_BIT]        = r.sleep_n;
                    n.rdata[CTRL_METHOD_LSB +: 2] = r.method;
                end
                IDX_STATUS: begin
                    n.rdata[STAT_BUSY_BIT]  = (r.state != ST_IDLE) || r.start_pend;
                    n.rdata[STAT_DONE_BIT]  = r.done;
                    n.rdata[STAT_READY_BIT] = r.sleep_n && (r.wake_cnt == '0);
                    n.rdata[STAT_INIT_BIT]  = r.init_done;
                end
                IDX_DATA: begin
                    n.rdata[7:0]               = r.result;
                    n.rdata[DATA_CHAN_LSB +: 3] = r.res_chan;
                    n.done                      = 1'b0;
                end
                default: begin
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end
        n.arready = !n.rvalid;

        // time since channel change or last strobe release
        if (n.chan != r.chan || !r.cs_n) begin
            n.stable_cnt = '0;
        end else if (r.stable_cnt != '1) begin
            n.stable_cnt = r.stable_cnt + CNT_W'(1);
        end

        case (r.state)
            ST_IDLE: begin
                if ((r.start_pend || !r.init_done) && r.sleep_n && r.wake_cnt == '0) begin // R5 R21
                    n.start_pend = 1'b0;
                    n.state      = ST_SETUP;
                    n.cnt        = ACQ_CYCLES - CNT_W'(1); // R7 R15
                end
            end
            ST_SETUP: begin
                if (r.cnt != '0) begin
                    n.cnt = r.cnt - CNT_W'(1);
                end else begin
                    n.cs_n = 1'b0; // R19
                    if (!r.mode) begin
                        n.rd_n  = 1'b0; // R8
                        // synced ready still shows the idle level for two edges
                        n.cnt   = CNT_W'(SYNC_CYC);
                        n.state = ST_READ;
                    end else begin
                        n.wr_n  = 1'b0; // R12
                        n.rd_n  = (r.method != METHOD_PIPE); // R18
                        n.cnt   = WR_CYCLES - CNT_W'(1);
                        n.state = ST_STROBE;
                    end
                end
            end
            ST_STROBE: begin
                if (r.cnt != '0) begin
                    n.cnt = r.cnt - CNT_W'(1);
                end else if (r.method == METHOD_PIPE) begin
                    capture = 1'b1; // R18
                    n.wr_n  = 1'b1;
                    n.rd_n  = 1'b1;
                    n.cs_n  = 1'b1;
                    n.state = ST_FINISH;
                end else begin
                    n.wr_n  = 1'b1; // R13
                    n.cnt   = GAP_CYCLES - CNT_W'(1);
                    n.state = ST_GAP;
                end
            end
            ST_GAP: begin
                if (r.method == METHOD_EARLY) begin
                    if (r.cnt != '0) begin
                        n.cnt = r.cnt - CNT_W'(1);
                    end else begin
                        n.rd_n  = 1'b0; // R16 R17
                        n.cnt   = ACCESS_CYCLES - CNT_W'(1);
                        n.state = ST_READ;
                    end
                end else if (!int_n_s) begin
                    n.rd_n  = 1'b0; // R14
                    n.cnt   = ACCESS_CYCLES - CNT_W'(1);
                    n.state = ST_READ;
                end
            end
            ST_READ: begin
                if (r.cnt != '0) begin
                    n.cnt = r.cnt - CNT_W'(1);
                end else if (!r.mode) begin
                    if (rdy_s && !int_n_s) begin // R9 R10 R11
                        capture = 1'b1;
                    end
                end else begin
                    capture = 1'b1; // R14
                end
                if (capture) begin
                    n.rd_n  = 1'b1; // R22
                    n.cs_n  = 1'b1;
                    n.state = ST_FINISH;
                end
            end
            ST_FINISH: begin
                n.state = ST_IDLE;
            end
            default: begin
                n.state = ST_IDLE;
                n.cs_n  = 1'b1;
                n.rd_n  = 1'b1;
                n.wr_n  = 1'b1;
            end
        endcase

        // set wins over a data read clearing the flag
        if (capture) begin
            if (r.init_done) begin
                n.result   = res_s; // R1
                n.res_chan = r.chan;
                n.done     = 1'b1;
            end else begin
                n.init_done = 1'b1; // R21
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r          <= '0;
            r.cs_n     <= 1'b1;
            r.rd_n     <= 1'b1;
            r.wr_n     <= 1'b1;
            r.sleep_n  <= 1'b1;
            r.wake_cnt <= WAKE_CYCLES;
        end else begin
            r <= n;
        end
    end

    assign awready          = r.awready;
    assign wready           = r.wready;
    assign bresp            = r.bresp;
    assign bvalid           = r.bvalid;
    assign arready          = r.arready;
    assign rdata            = r.rdata;
    assign rresp            = r.rresp;
    assign rvalid           = r.rvalid;
    assign cs_n             = r.cs_n;
    assign rd_n             = r.rd_n;
    assign wr_rdy_out       = r.wr_n;
    assign wr_rdy_oe        = r.mode;
    assign mode_sel         = r.mode;
    assign sleep_n          = r.sleep_n;
    assign channel_sel_bit0 = r.chan[0];
    assign channel_sel_bit1 = r.chan[1];
    assign channel_sel_bit2 = r.chan[2];

    localparam int GAP_D = GAP_CYCLES;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_WAKE_HOLDOFF: assert property ($fell(r.cs_n) |-> r.sleep_n && r.wake_cnt == '0) // R5
        else $error("conversion started before wake-up time elapsed");
    AST_ACQ_TIME: assert property ($fell(r.cs_n) |-> r.stable_cnt >= ACQ_CYCLES) // R7
        else $error("channel or acquisition time too short before conversion");
    AST_READ_START: assert property ($fell(r.rd_n) && !r.mode |-> !r.cs_n && r.wr_n) // R8
        else $error("read mode start without chip select");
    AST_READ_WAIT: assert property ($rose(r.rd_n) && !r.mode |-> $past(rdy_s && !int_n_s)) // R9
        else $error("read released before conversion end");
    AST_EARLY_GAP: assert property (
        $rose(r.wr_n) && r.mode && r.method == METHOD_EARLY |-> ##GAP_D $fell(r.rd_n)) // R17
        else $error("early read not issued at the fixed delay");
    AST_PIPE_TIED: assert property (r.mode && r.method == METHOD_PIPE |-> r.wr_n == r.rd_n) // R18
        else $error("pipelined strobes not tied");
    AST_CS_WITH_STROBE: assert property (!r.rd_n || !r.wr_n |-> !r.cs_n) // R19
        else $error("strobe active without chip select");
    AST_INIT_DISCARD: assert property (capture && !r.init_done |=> r.init_done && !r.done) // R21
        else $error("first conversion not discarded");
    AST_DONE_SET: assert property (capture && r.init_done |=> r.done && r.result == $past(res_s)) // R14
        else $error("captured result not flagged");
    AST_BRESP_HOLD: assert property (r.bvalid && !bready |=> r.bvalid && $stable(r.bresp))
        else $error("write response dropped before taken");

    COV_READ_MODE: cover property (capture && !r.mode && r.init_done);
    COV_WAIT_INT: cover property (capture && r.mode && r.method == METHOD_WAIT_INT);
    COV_EARLY: cover property (capture && r.mode && r.method == METHOD_EARLY);
    COV_PIPE: cover property (capture && r.mode && r.method == METHOD_PIPE && r.init_done);

endmodule

`default_nettype wire

//--- bench/adc_device_model.sv
`timescale 1ns/1ps
`default_nettype none

module adc_device_model #(
    parameter int INTL_NS = 300,
    parameter int PIPE_NS = 100,
    parameter int CONV_NS = 400,
    parameter int WAKE_NS = 360,
    parameter int ACQ_NS  = 160
) (
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       mode,
    input  wire logic       sleep_n,
    input  wire logic [2:0] chan,
    output logic            rdy_pull,
    output logic            int_n,
    output logic [7:0]      bus
);
    logic [7:0] res;
    logic [7:0] smp;
    logic [3:0] upper;
    logic       conv;
    logic       pipe;
    logic       early;
    int         convs;
    int         viol;
    time        t_wake;
    time        t_ready;
    time        t_wrf;
    time        t_rdf;

    function automatic logic [7:0] sample(input logic [2:0] c);
        return (c == 3'h7) ? 8'hFF : {1'b0, c, ~c, 1'b1};
    endfunction

    assign smp = sample(chan);

    task automatic begin_conv;
        if (!sleep_n || $time - t_wake < WAKE_NS || $time - t_ready < ACQ_NS) viol++;
        convs++;
        conv = 1'b1;
    endtask

    // upper nibble from the first pass, lower from the residue pass
    task automatic finish_conv(input logic [3:0] hi);
        res = {hi, smp[3:0]};
        int_n = 1'b0;
        t_ready = $time;
        conv = 1'b0;
    endtask

    initial begin
        res = 8'h00;
        upper = 4'h0;
        conv = 1'b0;
        pipe = 1'b0;
        early = 1'b0;
        int_n = 1'b1;
        rdy_pull = 1'b0;
        convs = 0;
        viol = 0;
        t_wake = 0;
        t_ready = 0;
        t_wrf = 0;
        t_rdf = 0;
    end

    always @(posedge sleep_n) t_wake = $time;

    // released bus shows the inverse of the last result
    always @* bus = (!cs_n && !rd_n) ? res : ~res;

    always @(posedge cs_n or posedge rd_n) int_n = 1'b1;

    always @(negedge cs_n or negedge rd_n) begin
        if (mode !== 1'b1 && !cs_n && !rd_n && !conv) begin
            begin_conv;
            rdy_pull = 1'b1;
            #CONV_NS;
            finish_conv(smp[7:4]);
            rdy_pull = 1'b0;
        end
    end

    always @(negedge wr_n) begin
        t_wrf = $time;
        #1;
        if (mode === 1'b1 && !cs_n) begin
            pipe = !rd_n;
            early = 1'b0;
            begin_conv;
        end
    end

    always @(posedge wr_n) begin
        if (mode === 1'b1 && conv) begin
            upper = smp[7:4];
            #(pipe ? PIPE_NS : INTL_NS);
            if (conv) finish_conv(upper);
        end
    end

    always @(negedge rd_n) begin
        t_rdf = $time;
        #1;
        if (mode === 1'b1 && conv && wr_n && !cs_n && !pipe) begin
            early = 1'b1;
            finish_conv(upper);
        end
    end
endmodule

`default_nettype wire

//--- bench/adc_host_tb.sv
`timescale 1ns/1ps
`default_nettype none

module adc_host_tb;
    import adc_host_pkg::*;
    logic              aclk;
    logic              aresetn;
    logic [ADDR_W-1:0] awaddr;
    logic [ADDR_W-1:0] araddr;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [31:0]       wdata, rdata, d;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, r;
    logic              cs_n, rd_n, wr_rdy_out, wr_rdy_oe, conv_done_n, mode_sel, sleep_n;
    logic              channel_sel_bit0, channel_sel_bit1, channel_sel_bit2, rdy_pull;
    logic [7:0]        result_bus;
    wire logic         wr_pin;
    int                err_count = 0;
    int                num_checks = 0;
    int                cycles = 0;

    // ready line has only the board pull-up behind it
    assign wr_pin = wr_rdy_oe ? wr_rdy_out : !rdy_pull;

    adc_host i_adc_host (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cs_n(cs_n), .rd_n(rd_n), .wr_rdy_out(wr_rdy_out), .wr_rdy_oe(wr_rdy_oe),
        .wr_rdy_in(wr_pin), .conv_done_n(conv_done_n), .result_bus(result_bus),
        .mode_sel(mode_sel), .sleep_n(sleep_n), .channel_sel_bit0(channel_sel_bit0),
        .channel_sel_bit1(channel_sel_bit1), .channel_sel_bit2(channel_sel_bit2)
    );

    adc_device_model i_adc_device_model (
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_pin), .mode(mode_sel), .sleep_n(sleep_n),
        .chan({channel_sel_bit2, channel_sel_bit1, channel_sel_bit0}),
        .rdy_pull(rdy_pull), .int_n(conv_done_n), .bus(result_bus)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            stop_test;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ad;
        ad = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (!ad && arready) begin
                ad = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                v = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic run(input logic [2:0] ch, input logic md, input logic [1:0] meth,
                       input logic [7:0] exp8);
        logic [31:0] v;
        logic [1:0]  rs;
        axi_write(4'h0, {24'h0, meth, 1'b1, md, ch, 1'b1}, rs);
        check(32'(rs), 32'(RESP_OKAY));
        for (int i = 0; i < 100; i++) begin
            axi_read(4'h4, v, rs);
            if (v[STAT_DONE_BIT] === 1'b1) break;
        end
        check(32'(v[STAT_DONE_BIT]), 32'h00000001);
        axi_read(4'h8, v, rs);
        check(v, {21'h0, ch, exp8});
        axi_read(4'h4, v, rs);
        check(32'(v[STAT_DONE_BIT]), 32'h00000000);
        $display("conversion ch %0d mode %0d method %0d finished", ch, md, meth);
    endtask

    initial begin
        aresetn = 1'b0;
        awaddr = '0;
        araddr = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(4'h0, d, r);
        check(d, 32'h00000020);
        for (int i = 0; i < 100; i++) begin
            axi_read(4'h4, d, r);
            if (d[STAT_INIT_BIT] === 1'b1) break;
        end
        // poll may land on the finishing cycle, still busy
        axi_read(4'h4, d, r);
        check(d, 32'h0000000C);
        check(32'(i_adc_device_model.convs), 32'h00000001);
        $display("reset and initial conversion finished");
        for (int c = 0; c < 8; c++) begin
            run(3'(c), 1'b0, 2'h0, i_adc_device_model.sample(3'(c)));
        end
        run(3'h5, 1'b1, 2'h0, i_adc_device_model.sample(3'h5));
        check(32'(i_adc_device_model.early), 32'h00000000);
        run(3'h4, 1'b1, 2'h1, i_adc_device_model.sample(3'h4));
        check(32'(i_adc_device_model.early), 32'h00000001);
        check(32'(i_adc_device_model.t_rdf - i_adc_device_model.t_wrf),
              32'(WR_PULSE_NS + WR_TO_RD_NS));
        run(3'h1, 1'b1, 2'h2, i_adc_device_model.sample(3'h4));
        run(3'h2, 1'b1, 2'h2, i_adc_device_model.sample(3'h1));
        axi_write(4'h0, 32'h0000000D, r);
        repeat (5) @(posedge aclk);
        check(32'(sleep_n), 32'h00000000);
        axi_read(4'h4, d, r);
        check(32'(d[STAT_BUSY_BIT]), 32'h00000001);
        run(3'h6, 1'b0, 2'h0, i_adc_device_model.sample(3'h6));
        $display("sleep and wake finished");
        axi_write(4'hC, 32'h000000FF, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_read(4'hC, d, r);
        check(32'(r), 32'(RESP_SLVERR));
        check(d, 32'h00000000);
        check(32'(i_adc_device_model.viol), 32'h00000000);
        $display("unmapped access finished");
        stop_test;
    end
endmodule

`default_nettype wire
